// File: bench/estq_target_model.sv
// Purpose: Model of the watched target buses, one match set per cycle
// Assumes: Bench asks for one instruction cycle at a time
// Notes: Outputs change just after a rising edge and last one cycle
`default_nettype none
`timescale 1ns/1ps
module estq_target_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Bench request, bits {full, D, C, B, A}
  input wire logic [4:0] ev_req,
  // Monitored matches
  output logic [3:0] event_cmp,
  output logic buffer_full
);
  // Register the request each clock; outputs follow ev_req one clock later
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      event_cmp <= 4'h0;
      buffer_full <= 1'b0;
    end else begin
      event_cmp <= ev_req[3:0];
      buffer_full <= ev_req[4];
    end
  end
endmodule // estq_target_model
`default_nettype wire

// File: bench/event_sequencer_trace_qualifier_tb_top.sv
// Purpose: Self-checking bench for the sequencer and trace qualifier
// Assumes: Zero wait state register bus, events one cycle each
// Notes: Random setups are checked against a level model function
`default_nettype none
`timescale 1ns/1ps
module event_sequencer_trace_qualifier_tb_top;
  // Clock, reset and bus master signals
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] ev_req = 5'h0;
  // Design outputs
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] event_cmp;
  logic buffer_full;
  logic trace_active;
  logic seq_done;
  logic hw_breakpoint;
  logic trigger_pulse;
  logic [2:0] seq_level;
  // Bench state
  int fails = 0;
  int num_checks = 0;
  logic [5:0] adv [8];
  logic [5:0] rst [8];
  logic [2:0] nlvl;
  logic [31:0] rd;
  logic [2:0] cap;
  logic [3:0] exp;
  logic [3:0] e;
  logic [2:0] lvm;

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // Design under test, hready fed from the only slave
  estq_top u_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .event_cmp(event_cmp),
    .buffer_full(buffer_full), .trace_active(trace_active),
    .seq_done(seq_done), .hw_breakpoint(hw_breakpoint),
    .trigger_pulse(trigger_pulse), .seq_level(seq_level));

  // Far side: target bus matches
  estq_target_model u_tgt (.sys_clk(sys_clk), .reset(reset),
    .ev_req(ev_req), .event_cmp(event_cmp), .buffer_full(buffer_full));

  // Count a comparison, report a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  endtask

  // Level and trace flag comparisons
  task automatic lv(input logic [2:0] w);
    chk({29'h0, seq_level}, {29'h0, w});
  endtask
  task automatic tr(input logic w);
    chk({31'h0, trace_active}, {31'h0, w});
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr_n, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr_n;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] w);
    bus(1'b0, a, 32'h0, rd);
    chk(rd, w);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // One instruction cycle of matches; pulses captured after sampling
  task automatic ev(input logic [4:0] v);
    @(posedge sys_clk);
    ev_req <= v;
    @(posedge sys_clk);
    ev_req <= 5'h0;
    @(negedge sys_clk);
    @(negedge sys_clk);
    cap = {trigger_pulse, hw_breakpoint, seq_done};
    @(negedge sys_clk);
    cap = cap | {trigger_pulse, hw_breakpoint, 1'b0};
    @(negedge sys_clk);
  endtask

  // Clear setup, then load advance and reset masks
  task automatic zap();
    foreach (adv[i]) begin
      adv[i] = 6'h0;
      rst[i] = 6'h0;
    end
  endtask
  task automatic cfg(input logic [2:0] n);
    logic [23:0] al;
    logic [23:0] ah;
    logic [23:0] rl;
    logic [23:0] rh;
    for (int i = 0; i < 4; i++) begin
      al[6*i +: 6] = adv[i];
      ah[6*i +: 6] = adv[i+4];
      rl[6*i +: 6] = rst[i];
      rh[6*i +: 6] = rst[i+4];
    end
    nlvl = n;
    wr(estq_pkg::OFF_CTRL, 32'h2);
    wr(estq_pkg::OFF_ADV_LO, {8'h0, al});
    wr(estq_pkg::OFF_ADV_HI, {8'h0, ah});
    wr(estq_pkg::OFF_RST_LO, {8'h0, rl});
    wr(estq_pkg::OFF_RST_HI, {8'h0, rh});
  endtask
  task automatic go();
    wr(estq_pkg::OFF_CTRL, {25'h0, nlvl, 4'h1});
  endtask

  // Expected {done, level}: advance beats reset, wrap after last
  function automatic logic [3:0] nxt(input logic [2:0] l,
                                     input logic [3:0] m);
    if (|(adv[l][3:0] & m)) return (l == nlvl) ? 4'h8 : {1'b0, l + 3'h1};
    if (|(rst[l][3:0] & m)) return 4'h0;
    return {1'b0, l};
  endfunction

  // Verdict and end of run
  task automatic results();
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    results();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h9aeb11bc));
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    // Register defaults, unmapped place, clear
    rdc(estq_pkg::OFF_CTRL, 32'h0);
    rdc(estq_pkg::OFF_TSQ, 32'hff);
    rdc(8'h3c, 32'h0);
    wr(estq_pkg::OFF_TSQ, 32'h0f);
    rdc(estq_pkg::OFF_TSQ, 32'h0f);
    wr(estq_pkg::OFF_CTRL, 32'h2);
    rdc(estq_pkg::OFF_TSQ, 32'hff);
    // A, A, B with A as reset while awaiting the third level
    zap();
    adv[0] = 6'h01;
    adv[1] = 6'h01;
    adv[2] = 6'h02;
    rst[2] = 6'h01;
    cfg(3'h2);
    wr(estq_pkg::OFF_ACTION, 32'h380);
    wr(estq_pkg::OFF_TRACE, 32'h1ff00);
    go();
    ev(5'h00);
    tr(1'b1);
    ev(5'h04);
    lv(3'h0);
    ev(5'h01);
    ev(5'h01);
    lv(3'h2);
    ev(5'h01);
    lv(3'h0);
    chk({29'h0, cap}, 32'h0);
    ev(5'h02);
    lv(3'h0);
    ev(5'h01);
    ev(5'h01);
    ev(5'h03);
    lv(3'h0);
    chk({29'h0, cap}, 32'h7);
    tr(1'b0);
    // Trace start gated by level permission
    zap();
    adv[0] = 6'h01;
    adv[1] = 6'h08;
    cfg(3'h1);
    wr(estq_pkg::OFF_TRACE, 32'h20201);
    go();
    ev(5'h02);
    tr(1'b1);
    ev(5'h04);
    tr(1'b0);
    wr(estq_pkg::OFF_TSQ, 32'hfe);
    ev(5'h02);
    tr(1'b0);
    ev(5'h01);
    tr(1'b0);
    ev(5'h02);
    tr(1'b1);
    ev(5'h10);
    tr(1'b0);
    ev(5'h02);
    tr(1'b0);
    rdc(estq_pkg::OFF_STATUS, 32'h41);
    // First counter clocked by A, reloaded by B, zero advances
    zap();
    adv[0] = 6'h10;
    adv[1] = 6'h04;
    cfg(3'h1);
    wr(estq_pkg::OFF_FIRST_COUNTER, 32'h30100);
    go();
    ev(5'h01);
    ev(5'h01);
    ev(5'h02);
    ev(5'h01);
    ev(5'h01);
    lv(3'h0);
    ev(5'h01);
    lv(3'h1);
    // Random masks and events against the level model
    for (int c = 0; c < 4; c++) begin
      foreach (adv[i]) begin
        adv[i] = 6'($urandom) & 6'h0f;
        rst[i] = 6'($urandom) & 6'($urandom) & 6'h0f;
      end
      cfg((c == 0) ? 3'h7 : 3'($urandom));
      go();
      lvm = 3'h0;
      for (int k = 0; k < 40; k++) begin
        e = 4'($urandom) & 4'($urandom);
        exp = nxt(lvm, e);
        ev({1'b0, e});
        lv(exp[2:0]);
        chk({31'h0, cap[0]}, {31'h0, exp[3]});
        lvm = exp[2:0];
      end
    end
    results();
  end
endmodule // event_sequencer_trace_qualifier_tb_top
`default_nettype wire

// File: hw/estq_ahb_slave.sv
// Purpose: AHB-Lite slave front end, turns transfers into strobes
// Assumes: Single word transfers, zero wait states
// Notes: Always OKAY; read data muxed by the core
`default_nettype none
`timescale 1ns/1ps
module estq_ahb_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  // Register side
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [31:0] wdata
);
  // Captured address phase
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic take;

  // Valid NONSEQ or SEQ transfer accepted
  assign take = hsel && hready && htrans[1];

  // Latch address phase
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = wr_pend_reg;
  assign rd_en = take && !hwrite;
  assign addr = wr_pend_reg ? addr_reg : haddr[7:0];
  assign wdata = hwdata;
endmodule // estq_ahb_slave
`default_nettype wire

// File: hw/estq_counter.sv
// Purpose: Event counter, clocked by one input and reloaded by another
// Assumes: Inputs synchronous to sys_clk
// Notes: Reload wins over clock; wraps to initial value at zero
`default_nettype none
`timescale 1ns/1ps
module estq_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic clr,
  input wire logic run,
  input wire logic clk_evt,
  input wire logic rld_evt,
  input wire logic dec_evt,
  input wire logic [WIDTH-1:0] init_val,
  // Status
  output logic [WIDTH-1:0] value,
  output logic zero
);
  // Counter state
  logic [WIDTH-1:0] value_reg;
  logic zero_reg;

  // Count down, reload on event or after reaching zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      value_reg <= '0;
      zero_reg <= 1'b0;
    end else if (clr) begin
      value_reg <= init_val;
      zero_reg <= 1'b0;
    end else if (rld_evt) begin
      value_reg <= init_val;
      zero_reg <= 1'b0;
    end else if (run && (clk_evt || dec_evt)) begin
      if (value_reg == {{(WIDTH-1){1'b0}}, 1'b1} || value_reg == '0) begin
        value_reg <= init_val;
        zero_reg <= 1'b1;
      end else begin
        value_reg <= value_reg - 1'b1;
        zero_reg <= 1'b0;
      end
    end else begin
      zero_reg <= 1'b0;
    end
  end

  assign value = value_reg;
  assign zero = zero_reg;

  // Reload restores the initial value
  a_cnt_reload: assert property (@(posedge sys_clk) disable iff (reset)
    rld_evt && !clr |=> value == $past(init_val))
    else $error("counter did not reload");
endmodule // estq_counter
`default_nettype wire

// File: hw/estq_pkg.sv
// Purpose: Shared constants for the event sequencer and trace qualifier
// Assumes: One 50 MHz clock, AHB-Lite register access
// Notes: Offsets are byte addresses of aligned 32-bit words
package estq_pkg;
  // Input counts
  localparam int NUM_INPUTS = 6;
  localparam int MAX_LEVELS = 8;
  localparam int LVL_W = 3;
  localparam int CNT_W = 16;
  // Input indices: four comparators then two counters
  localparam int IN_FIRST_COUNTER = 4;
  localparam int IN_SECOND_COUNTER = 5;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADV_LO = 8'h04;
  localparam logic [7:0] OFF_ADV_HI = 8'h08;
  localparam logic [7:0] OFF_RST_LO = 8'h0c;
  localparam logic [7:0] OFF_RST_HI = 8'h10;
  localparam logic [7:0] OFF_TSQ = 8'h14;
  localparam logic [7:0] OFF_TRACE = 8'h18;
  localparam logic [7:0] OFF_ACTION = 8'h1c;
  localparam logic [7:0] OFF_FIRST_COUNTER = 8'h20;
  localparam logic [7:0] OFF_SECOND_COUNTER = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  // Control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_NLVL_LSB = 4;
  // Trace fields: start select, stop select, flags
  localparam int TR_START_LSB = 0;
  localparam int TR_STOP_LSB = 8;
  localparam int TR_IMM_BIT = 16;
  localparam int TR_DOF_BIT = 17;
  // Counter config fields: clock sel, reload sel, initial value
  localparam int CC_CLK_LSB = 0;
  localparam int CC_RLD_LSB = 8;
  localparam int CC_INIT_LSB = 16;
  // Completion action bits
  localparam int ACT_CNT_START = 0;
  localparam int ACT_CNT_STOP = 1;
  localparam int ACT_CNT_DEC = 2;
  localparam int ACT_CNT_RELOAD = 3;
  localparam int ACT_CNT_SEL = 4;
  localparam int ACT_TR_START = 5;
  localparam int ACT_TR_STOP = 6;
  localparam int ACT_TR_DIS = 7;
  localparam int ACT_BRK = 8;
  localparam int ACT_TRIG = 9;
  // Reset values
  localparam logic [7:0] TSQ_RESET = 8'hff;
  localparam logic [2:0] NLVL_RESET = 3'h0;
endpackage : estq_pkg

// File: hw/estq_top.sv
// Purpose: Multi-level event sequencer with trace-start qualifier
// Assumes: Events sampled once per instruction cycle on sys_clk
// Notes: Registers on AHB-Lite; read data registered
// Contract
// - Reset condition of awaited level resets sequencer
// - After reset, search level one again
// - Resetting event never counts as level one
// - Unrelated events leave level unchanged
// - All levels in order signal completion
// - Simultaneous advance and reset: advance wins
// - Simultaneous final advance completes sequence
// - Trace starts on event AND qualifier
// - Clear makes qualifier permit every level
// - Blocked level never starts trace
// - Trace waits for a permitted level
// - Start, stop, disable-on-full trace control
// - Counter clocked and reloaded by events
// - Six inputs, any as advance or reset
// - Up to eight levels, strictly ordered
// - After last level, search level one
// - Completion drives selectable actions
//
// Chosen here: the AHB-Lite register port and the register offsets.
`default_nettype none
`timescale 1ns/1ps
module estq_top #(
  parameter int CNT_W = estq_pkg::CNT_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Monitored events
  input wire logic [3:0] event_cmp,
  input wire logic buffer_full,
  // Outputs to trace and target
  output logic trace_active,
  output logic seq_done,
  output logic hw_breakpoint,
  output logic trigger_pulse,
  output logic [2:0] seq_level
);
  localparam int NI = estq_pkg::NUM_INPUTS;
  localparam int NL = estq_pkg::MAX_LEVELS;

  // Bus strobes
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  // Configuration registers
  logic enable_reg;
  logic [2:0] nlvl_reg; // Last level index (levels = value+1)
  logic [47:0] adv_reg; // Six bits per level
  logic [47:0] rst_reg;
  logic [7:0] tsq_reg; // Trace_start_qualifier, 1 = permitted
  logic [31:0] trace_cfg_reg;
  logic [9:0] action_reg;
  logic [31:0] first_counter_cfg_reg;
  logic [31:0] second_counter_cfg_reg;
  logic [31:0] rdata_reg;
  // Sequencer and trace state
  logic [2:0] level_reg;
  logic done_reg;
  logic trace_reg;
  logic disabled_reg;
  logic brk_reg;
  logic trig_reg;
  logic [1:0] cnt_run_reg;
  // Combinational terms
  logic clr;
  logic [NI-1:0] inputs;
  logic [NI-1:0] adv_sel;
  logic [NI-1:0] rst_sel;
  logic adv_hit;
  logic rst_hit;
  logic complete;
  logic start_evt;
  logic stop_evt;
  logic [CNT_W-1:0] first_counter_val;
  logic [CNT_W-1:0] second_counter_val;
  logic first_counter_zero;
  logic second_counter_zero;
  logic cnt_load; // Load initial value on clear or enable write

  // Pick an input by a one-hot-free index; out of range reads false
  function automatic logic pick(input logic [NI-1:0] v,
                                input logic [7:0] sel);
    if (sel < 8'(NI)) begin
      return v[sel[2:0]];
    end
    return 1'b0;
  endfunction

  // Bus front end
  estq_ahb_slave u_bus (
    .sys_clk(sys_clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr),
    .wdata(wdata)
  );

  // Clear strobe from control write
  assign clr = wr_en && addr == estq_pkg::OFF_CTRL &&
               wdata[estq_pkg::CTRL_CLR_BIT];

  // Configuration writes; clear restores defaults
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enable_reg <= 1'b0;
      nlvl_reg <= estq_pkg::NLVL_RESET;
      adv_reg <= '0;
      rst_reg <= '0;
      tsq_reg <= estq_pkg::TSQ_RESET;
      trace_cfg_reg <= '0;
      action_reg <= '0;
      first_counter_cfg_reg <= '0;
      second_counter_cfg_reg <= '0;
    end else if (clr) begin
      enable_reg <= 1'b0;
      nlvl_reg <= estq_pkg::NLVL_RESET;
      adv_reg <= '0;
      rst_reg <= '0;
      tsq_reg <= estq_pkg::TSQ_RESET;
      trace_cfg_reg <= '0;
      action_reg <= '0;
      first_counter_cfg_reg <= '0;
      second_counter_cfg_reg <= '0;
    end else if (wr_en) begin
      case (addr)
        estq_pkg::OFF_CTRL: begin
          enable_reg <= wdata[estq_pkg::CTRL_EN_BIT];
          nlvl_reg <= wdata[estq_pkg::CTRL_NLVL_LSB +: 3];
        end
        estq_pkg::OFF_ADV_LO: adv_reg[23:0] <= wdata[23:0];
        estq_pkg::OFF_ADV_HI: adv_reg[47:24] <= wdata[23:0];
        estq_pkg::OFF_RST_LO: rst_reg[23:0] <= wdata[23:0];
        estq_pkg::OFF_RST_HI: rst_reg[47:24] <= wdata[23:0];
        estq_pkg::OFF_TSQ: tsq_reg <= wdata[7:0];
        estq_pkg::OFF_TRACE: trace_cfg_reg <= wdata;
        estq_pkg::OFF_ACTION: action_reg <= wdata[9:0];
        estq_pkg::OFF_FIRST_COUNTER: first_counter_cfg_reg <= wdata;
        estq_pkg::OFF_SECOND_COUNTER: second_counter_cfg_reg <= wdata;
        default: begin
        end
      endcase
    end
  end

  // Read mux, registered for the data phase
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
    end else if (rd_en) begin
      // Own address phase; addr may still hold a pending write's address
      case (haddr[7:0])
        estq_pkg::OFF_CTRL: rdata_reg <= {25'h0, nlvl_reg, 3'h0, enable_reg};
        estq_pkg::OFF_ADV_LO: rdata_reg <= {8'h0, adv_reg[23:0]};
        estq_pkg::OFF_ADV_HI: rdata_reg <= {8'h0, adv_reg[47:24]};
        estq_pkg::OFF_RST_LO: rdata_reg <= {8'h0, rst_reg[23:0]};
        estq_pkg::OFF_RST_HI: rdata_reg <= {8'h0, rst_reg[47:24]};
        estq_pkg::OFF_TSQ: rdata_reg <= {24'h0, tsq_reg};
        estq_pkg::OFF_TRACE: rdata_reg <= trace_cfg_reg;
        estq_pkg::OFF_ACTION: rdata_reg <= {22'h0, action_reg};
        estq_pkg::OFF_FIRST_COUNTER: rdata_reg <= first_counter_cfg_reg;
        estq_pkg::OFF_SECOND_COUNTER: rdata_reg <= second_counter_cfg_reg;
        estq_pkg::OFF_STATUS: begin
          rdata_reg <= {second_counter_val, 8'h0, 1'b0, disabled_reg, trace_reg,
                        done_reg, 1'b0, level_reg};
        end
        default: rdata_reg <= '0;
      endcase
    end
  end
  assign hrdata = rdata_reg;

  // Six sequencer inputs: four comparators, two counters
  assign inputs = {second_counter_zero, first_counter_zero, event_cmp};

  // Per-level selections for the awaited level
  assign adv_sel = adv_reg[level_reg*NI +: NI];
  assign rst_sel = rst_reg[level_reg*NI +: NI];
  assign adv_hit = enable_reg && |(inputs & adv_sel);
  assign rst_hit = enable_reg && |(inputs & rst_sel);
  assign complete = adv_hit && level_reg == nlvl_reg;

  // Level register: advance beats reset, else hold
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      level_reg <= 3'h0;
    end else if (clr) begin
      level_reg <= 3'h0;
    end else if (adv_hit) begin
      if (complete) begin
        level_reg <= 3'h0;
      end else begin
        level_reg <= level_reg + 3'h1;
      end
    end else if (rst_hit) begin
      level_reg <= 3'h0;
    end
    // Otherwise unchanged
  end

  // Completion pulse and its selected actions
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      done_reg <= 1'b0;
      brk_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      done_reg <= complete && !clr;
      brk_reg <= complete && !clr && action_reg[estq_pkg::ACT_BRK];
      trig_reg <= complete && !clr && action_reg[estq_pkg::ACT_TRIG];
    end
  end

  // Trace start and stop events; only start is gated by level qualifier
  assign start_evt = (trace_cfg_reg[estq_pkg::TR_IMM_BIT] ||
    pick(inputs, trace_cfg_reg[estq_pkg::TR_START_LSB +: 8]) ||
    (complete && action_reg[estq_pkg::ACT_TR_START]))
    && tsq_reg[level_reg];
  assign stop_evt = pick(inputs, trace_cfg_reg[estq_pkg::TR_STOP_LSB +: 8])
    || (complete && action_reg[estq_pkg::ACT_TR_STOP]);

  // Trace control state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trace_reg <= 1'b0;
      disabled_reg <= 1'b0;
    end else if (clr || !enable_reg) begin
      trace_reg <= 1'b0;
      disabled_reg <= 1'b0;
    end else begin
      if ((complete && action_reg[estq_pkg::ACT_TR_DIS]) ||
          (buffer_full && trace_cfg_reg[estq_pkg::TR_DOF_BIT])) begin
        disabled_reg <= 1'b1;
        trace_reg <= 1'b0;
      end else if (disabled_reg || stop_evt) begin
        trace_reg <= 1'b0;
      end else if (start_evt) begin
        trace_reg <= 1'b1;
      end
    end
  end

  // Counter run flags, started or stopped by completion
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_run_reg <= 2'h0;
    end else if (clr) begin
      cnt_run_reg <= 2'h0;
    end else if (complete && action_reg[estq_pkg::ACT_CNT_STOP]) begin
      cnt_run_reg[action_reg[estq_pkg::ACT_CNT_SEL]] <= 1'b0;
    end else if (complete && action_reg[estq_pkg::ACT_CNT_START]) begin
      cnt_run_reg[action_reg[estq_pkg::ACT_CNT_SEL]] <= 1'b1;
    end else if (wr_en && addr == estq_pkg::OFF_CTRL) begin
      cnt_run_reg <= {2{wdata[estq_pkg::CTRL_EN_BIT]}};
    end
  end

  // Counters start from their initial value, not from zero
  assign cnt_load = clr || (wr_en && addr == estq_pkg::OFF_CTRL &&
                    wdata[estq_pkg::CTRL_EN_BIT]);

  // First_counter and second_counter
  estq_counter #(.WIDTH(CNT_W)) u_first_counter (
    .sys_clk(sys_clk),
    .reset(reset),
    .clr(cnt_load),
    .run(cnt_run_reg[0] && enable_reg),
    .clk_evt(pick(inputs, first_counter_cfg_reg[estq_pkg::CC_CLK_LSB +: 8])),
    .rld_evt(pick(inputs, first_counter_cfg_reg[estq_pkg::CC_RLD_LSB +: 8]) ||
      (complete && action_reg[estq_pkg::ACT_CNT_RELOAD] &&
       !action_reg[estq_pkg::ACT_CNT_SEL])),
    .dec_evt(complete && action_reg[estq_pkg::ACT_CNT_DEC] &&
      !action_reg[estq_pkg::ACT_CNT_SEL]),
    .init_val(first_counter_cfg_reg[estq_pkg::CC_INIT_LSB +: CNT_W]),
    .value(first_counter_val),
    .zero(first_counter_zero)
  );
  estq_counter #(.WIDTH(CNT_W)) u_second_counter (
    .sys_clk(sys_clk),
    .reset(reset),
    .clr(cnt_load),
    .run(cnt_run_reg[1] && enable_reg),
    .clk_evt(pick(inputs, second_counter_cfg_reg[estq_pkg::CC_CLK_LSB +: 8])),
    .rld_evt(pick(inputs, second_counter_cfg_reg[estq_pkg::CC_RLD_LSB +: 8]) ||
      (complete && action_reg[estq_pkg::ACT_CNT_RELOAD] &&
       action_reg[estq_pkg::ACT_CNT_SEL])),
    .dec_evt(complete && action_reg[estq_pkg::ACT_CNT_DEC] &&
      action_reg[estq_pkg::ACT_CNT_SEL]),
    .init_val(second_counter_cfg_reg[estq_pkg::CC_INIT_LSB +: CNT_W]),
    .value(second_counter_val),
    .zero(second_counter_zero)
  );

  assign trace_active = trace_reg;
  assign seq_done = done_reg;
  assign hw_breakpoint = brk_reg;
  assign trigger_pulse = trig_reg;
  assign seq_level = level_reg;

  // Checks
  a_reset_to_one: assert property (@(posedge sys_clk) disable iff (reset)
    rst_hit && !adv_hit && !clr |=> level_reg == 3'h0)
    else $error("reset condition did not return to level one");
  a_adv_wins: assert property (@(posedge sys_clk) disable iff (reset)
    adv_hit && rst_hit && !complete && !clr
    |=> level_reg == $past(level_reg) + 3'h1)
    else $error("reset beat advance");
  a_ignore_other: assert property (@(posedge sys_clk) disable iff (reset)
    !adv_hit && !rst_hit && !clr |=> $stable(level_reg))
    else $error("level moved without cause");
  a_done_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    complete && !clr |=> seq_done ##1 (!seq_done || $past(complete)))
    else $error("completion not signalled");
  a_final_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    complete && !clr |=> level_reg == 3'h0)
    else $error("no return to level one after completion");
  a_block_level: assert property (@(posedge sys_clk) disable iff (reset)
    !trace_reg && !tsq_reg[level_reg] |=> !trace_reg)
    else $error("trace started at a blocked level");
  a_clear_tsq: assert property (@(posedge sys_clk) disable iff (reset)
    clr |=> tsq_reg == estq_pkg::TSQ_RESET)
    else $error("clear did not permit all levels");
  a_full_stop: assert property (@(posedge sys_clk) disable iff (reset)
    buffer_full && trace_cfg_reg[estq_pkg::TR_DOF_BIT] && enable_reg
    && !clr |=> !trace_reg [*2])
    else $error("trace kept running when buffer full");
  a_start_gate: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(trace_reg) |-> $past(start_evt))
    else $error("trace started without qualified start");
  c_complete: cover property (@(posedge sys_clk) complete);
  c_adv_rst: cover property (@(posedge sys_clk) adv_hit && rst_hit);
  c_trace_on: cover property (@(posedge sys_clk) $rose(trace_reg));
  c_reset_seq: cover property (@(posedge sys_clk)
    rst_hit && !adv_hit && level_reg != 3'h0);
endmodule // estq_top
`default_nettype wire
